//--- inc/tac_pkg.sv
// tac_pkg: register map, field layout, reset values and modes of the
// timer auxiliary control slice.
// assumes a 10-bit byte address on the register port, word aligned.
package tac_pkg;

	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int CH_NUM = 4;
	localparam int MEM_WORDS = 8;
	localparam int MEM_IDX_W = 3;

	// register byte offsets, first control register at zero
	localparam logic [ADDR_W-1:0] OFF_CTL0 = 10'h000;
	localparam logic [ADDR_W-1:0] OFF_CH0_CV = 10'h034;
	localparam logic [ADDR_W-1:0] OFF_CH3_CV = 10'h040;
	localparam logic [ADDR_W-1:0] OFF_CH0_ADD = 10'h064;
	localparam logic [ADDR_W-1:0] OFF_CH3_ADD = 10'h070;
	localparam logic [ADDR_W-1:0] OFF_AUX_CTRL = 10'h074;
	localparam logic [ADDR_W-1:0] OFF_WDG_PERIOD = 10'h094;
	localparam logic [ADDR_W-1:0] OFF_DMA_CFG = 10'h0E0;
	localparam logic [ADDR_W-1:0] OFF_DMA_WINDOW = 10'h0E4;
	localparam logic [ADDR_W-1:0] OFF_MISC_CFG = 10'h0FC;

	// reset values
	localparam logic [DATA_W-1:0] RST_AUX_CTRL = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_WDG_PERIOD = 32'hFFFF_FFFF;
	localparam logic [DATA_W-1:0] RST_DMA_CFG = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_MISC_CFG = 32'h0000_0000;

	// writable bits, reserved bits stay at reset value
	localparam logic [DATA_W-1:0] MASK_AUX_CTRL = 32'hF00C_FF00;
	localparam logic [DATA_W-1:0] MASK_DMA_CFG = 32'h0000_3F3F;
	localparam logic [DATA_W-1:0] MASK_MISC_CFG = 32'h0000_0002;

	// field positions
	localparam int CPWM_LSB = 28;
	localparam int DISC_DET_BIT = 19;
	localparam int JUMP_DET_BIT = 18;
	localparam int MPSEL_LSB = 8;
	localparam int MPSEL_W = 2;
	localparam int XFER_CNT_LSB = 8;
	localparam int XFER_CNT_W = 6;
	localparam int START_IDX_LSB = 0;
	localparam int START_IDX_W = 6;
	localparam int SKIP_SAME_BIT = 1;

	// bus timing: request edge to acknowledge, in clk cycles
	localparam int BUS_LATENCY = 2;

	typedef enum logic [1:0] {
		MP_NORMAL = 2'b00,
		MP_UP = 2'b01,
		MP_DOWN = 2'b10,
		MP_BOTH = 2'b11
	} tac_mpsel_e;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_EXEC = 1'b1
	} tac_bus_e;

endpackage

//--- hdl/tac_cmp_store.sv
// tac_cmp_store: preload words of the channel compare and additional
// compare values, one write port, registered read port, all words visible.
// assumes one write per cycle; read shows the value before a same-cycle write.
`timescale 1ns/100ps
module tac_cmp_store #(
	parameter int WORDS = 8,
	parameter int IDX_W = 3,
	parameter int DATA_W = 32
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic wrEn,
	input wire logic [IDX_W-1:0] wrIdx,
	input wire logic [DATA_W-1:0] wrData,
	input wire logic [IDX_W-1:0] rdIdx,
	output logic [DATA_W-1:0] rdData,
	output logic [WORDS*DATA_W-1:0] words
);

	typedef struct packed {
		logic [WORDS-1:0][DATA_W-1:0] mem;
		logic [DATA_W-1:0] rd;
	} tac_store_s;

	tac_store_s s_q;
	tac_store_s s_d;

	////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		s_d = s_q;
		s_d.rd = s_q.mem[rdIdx];
		if (wrEn)
		begin
			s_d.mem[wrIdx] = wrData;
		end
		if (!nrst)
		begin
			s_d = '0;
		end
	end

	always_ff @(posedge clk)
	begin
		s_q <= s_d;
	end

	assign rdData = s_q.rd;
	assign words = s_q.mem;

endmodule

//--- hdl/tac_aux_ctrl.sv
// tac_aux_ctrl: timer auxiliary control slice: composite pwm enables,
// match pulse shaping, decoder disconnect watchdog and jump detect,
// dma burst window remap and identical compare write filter.
// assumes one outstanding register request; quadrature inputs already synced.
`timescale 1ns/100ps
module tac_aux_ctrl (
	input wire logic clk,
	input wire logic nrst,
	input wire logic busValid,
	input wire logic busWrite,
	input wire logic [tac_pkg::ADDR_W-1:0] busAddr,
	input wire logic [tac_pkg::DATA_W-1:0] busWdata,
	output logic [tac_pkg::DATA_W-1:0] busRdata,
	output logic busAck,
	input wire logic cntUp,
	input wire logic [tac_pkg::CH_NUM-1:0] matchEvt,
	input wire logic [tac_pkg::CH_NUM-1:0] normalRef,
	input wire logic updateEvt,
	input wire logic [tac_pkg::CH_NUM-1:0] shadowEn,
	input wire logic quadA,
	input wire logic quadB,
	input wire logic disconnectIrqEn,
	input wire logic disconnectFlagClr,
	output logic [tac_pkg::CH_NUM-1:0] compareRef,
	output logic [tac_pkg::CH_NUM-1:0] compositePwmEn,
	output logic [tac_pkg::CH_NUM*tac_pkg::DATA_W-1:0] compareValue,
	output logic [tac_pkg::CH_NUM*tac_pkg::DATA_W-1:0] addCompareValue,
	output logic jumpDetected,
	output logic disconnectFlag,
	output logic disconnectIrq
);

	typedef struct packed {
		tac_pkg::tac_bus_e st;
		logic [tac_pkg::DATA_W-1:0] auxCtrl;
		logic [tac_pkg::DATA_W-1:0] wdgPeriod;
		logic [tac_pkg::DATA_W-1:0] dmaCfg;
		logic [tac_pkg::DATA_W-1:0] miscCfg;
		logic [tac_pkg::XFER_CNT_W-1:0] burstIdx;
		logic pWrite;
		logic [tac_pkg::ADDR_W-1:0] pAddr;
		logic [tac_pkg::DATA_W-1:0] pWdata;
		logic [tac_pkg::DATA_W-1:0] rdata;
		logic ack;
		logic prevA;
		logic prevB;
		logic [tac_pkg::DATA_W-1:0] cntA;
		logic [tac_pkg::DATA_W-1:0] cntB;
		logic flag;
		logic irq;
		logic jump;
		logic [tac_pkg::CH_NUM-1:0] chRef;
		logic [tac_pkg::CH_NUM-1:0][tac_pkg::DATA_W-1:0] cmpSh;
		logic [tac_pkg::CH_NUM-1:0][tac_pkg::DATA_W-1:0] addSh;
	} tac_state_s;

	tac_state_s s_q;
	tac_state_s s_d;

	logic memWrEn;
	logic [tac_pkg::MEM_IDX_W-1:0] memWrIdx;
	logic [tac_pkg::MEM_IDX_W-1:0] memRdIdx;
	logic [tac_pkg::DATA_W-1:0] memRdData;
	logic [tac_pkg::MEM_WORDS*tac_pkg::DATA_W-1:0] memWords;
	logic winHit;
	logic [tac_pkg::ADDR_W-1:0] effAddr;
	logic [3:0] slotReq;
	logic [3:0] slotExec;
	logic edgeA;
	logic edgeB;
	logic toA;
	logic toB;
	logic disEn;
	logic sameSkip;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// {hit, additional, channel} for the compare preload words
	function automatic logic [3:0] memSlot(input logic [tac_pkg::ADDR_W-1:0] a);
		logic [tac_pkg::ADDR_W-1:0] dc;
		logic [tac_pkg::ADDR_W-1:0] da;
		dc = a - tac_pkg::OFF_CH0_CV;
		da = a - tac_pkg::OFF_CH0_ADD;
		memSlot = 4'h0;
		if (a[1:0] == 2'h0 && a >= tac_pkg::OFF_CH0_CV && a <= tac_pkg::OFF_CH3_CV)
		begin
			memSlot = {2'b10, dc[3:2]};
		end
		else if (a[1:0] == 2'h0 && a >= tac_pkg::OFF_CH0_ADD && a <= tac_pkg::OFF_CH3_ADD)
		begin
			memSlot = {2'b11, da[3:2]};
		end
	endfunction

	// window target: start index plus transfer index, in words
	function automatic logic [tac_pkg::ADDR_W-1:0] winAddr(
		input logic [tac_pkg::START_IDX_W-1:0] startIdx,
		input logic [tac_pkg::XFER_CNT_W-1:0] idx
	);
		logic [tac_pkg::START_IDX_W:0] sum;
		sum = {1'b0, startIdx} + {1'b0, idx};
		winAddr = tac_pkg::OFF_CTL0 + {1'b0, sum, 2'b00};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// preload storage

	tac_cmp_store #(
		.WORDS(tac_pkg::MEM_WORDS),
		.IDX_W(tac_pkg::MEM_IDX_W),
		.DATA_W(tac_pkg::DATA_W)
	) u_store (
		.clk(clk),
		.nrst(nrst),
		.wrEn(memWrEn),
		.wrIdx(memWrIdx),
		.wrData(s_q.pWdata),
		.rdIdx(memRdIdx),
		.rdData(memRdData),
		.words(memWords)
	);

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		s_d = s_q;
		s_d.ack = 1'b0;
		memWrEn = 1'b0;
		winHit = busAddr == tac_pkg::OFF_DMA_WINDOW;
		effAddr = winHit ? winAddr(s_q.dmaCfg[tac_pkg::START_IDX_LSB +: tac_pkg::START_IDX_W],
			s_q.burstIdx) : busAddr;
		slotReq = memSlot(effAddr);
		slotExec = memSlot(s_q.pAddr);
		memRdIdx = slotReq[2:0];
		memWrIdx = slotExec[2:0];
		// only channel compare words are filtered, never the additional ones
		sameSkip = s_q.miscCfg[tac_pkg::SKIP_SAME_BIT] && !slotExec[2]
			&& memRdData == s_q.pWdata;

		unique case (s_q.st)
			tac_pkg::ST_IDLE:
			begin
				if (busValid)
				begin
					s_d.st = tac_pkg::ST_EXEC;
					s_d.pWrite = busWrite;
					s_d.pAddr = effAddr;
					s_d.pWdata = busWdata;
					if (winHit)
					begin
						if (s_q.burstIdx >= s_q.dmaCfg[tac_pkg::XFER_CNT_LSB +: tac_pkg::XFER_CNT_W])
						begin
							s_d.burstIdx = '0;
						end
						else
						begin
							s_d.burstIdx = s_q.burstIdx + 6'h01;
						end
					end
				end
			end
			tac_pkg::ST_EXEC:
			begin
				s_d.st = tac_pkg::ST_IDLE;
				s_d.ack = 1'b1;
				s_d.rdata = '0;
				if (s_q.pWrite)
				begin
					// reserved bits forced back so a careless write stays harmless
					unique case (s_q.pAddr)
						tac_pkg::OFF_AUX_CTRL: s_d.auxCtrl = s_q.pWdata & tac_pkg::MASK_AUX_CTRL;
						tac_pkg::OFF_WDG_PERIOD: s_d.wdgPeriod = s_q.pWdata;
						tac_pkg::OFF_DMA_CFG:
						begin
							s_d.dmaCfg = s_q.pWdata & tac_pkg::MASK_DMA_CFG;
							s_d.burstIdx = '0;
						end
						tac_pkg::OFF_MISC_CFG: s_d.miscCfg = s_q.pWdata & tac_pkg::MASK_MISC_CFG;
						default: memWrEn = slotExec[3] && !sameSkip;
					endcase
				end
				else
				begin
					unique case (s_q.pAddr)
						tac_pkg::OFF_AUX_CTRL: s_d.rdata = s_q.auxCtrl;
						tac_pkg::OFF_WDG_PERIOD: s_d.rdata = s_q.wdgPeriod;
						tac_pkg::OFF_DMA_CFG: s_d.rdata = s_q.dmaCfg;
						tac_pkg::OFF_MISC_CFG: s_d.rdata = s_q.miscCfg;
						default: s_d.rdata = slotExec[3] ? memRdData : '0;
					endcase
				end
			end
		endcase

		// disconnect watchdogs, one per input, each restarted by an edge on its own input
		disEn = s_q.auxCtrl[tac_pkg::DISC_DET_BIT];
		edgeA = quadA ^ s_q.prevA;
		edgeB = quadB ^ s_q.prevB;
		s_d.prevA = quadA;
		s_d.prevB = quadB;
		toA = disEn && !edgeA && s_q.cntA == s_q.wdgPeriod;
		toB = disEn && !edgeB && s_q.cntB == s_q.wdgPeriod;
		if (!disEn || edgeA || toA)
		begin
			s_d.cntA = '0;
		end
		else
		begin
			s_d.cntA = s_q.cntA + 32'h0000_0001;
		end
		if (!disEn || edgeB || toB)
		begin
			s_d.cntB = '0;
		end
		else
		begin
			s_d.cntB = s_q.cntB + 32'h0000_0001;
		end
		// a timeout in the clearing cycle still sets the flag
		s_d.flag = (s_q.flag && !disconnectFlagClr) || toA || toB;
		s_d.irq = s_d.flag && disconnectIrqEn;
		s_d.jump = s_q.auxCtrl[tac_pkg::JUMP_DET_BIT] && edgeA && edgeB;

		// match pulse shaping and shadow copies per channel
		for (int ch = 0; ch < tac_pkg::CH_NUM; ch++)
		begin
			unique case (tac_pkg::tac_mpsel_e'(s_q.auxCtrl[tac_pkg::MPSEL_LSB + 2*ch +: 2]))
				tac_pkg::MP_NORMAL: s_d.chRef[ch] = normalRef[ch];
				tac_pkg::MP_UP: s_d.chRef[ch] = matchEvt[ch] && cntUp;
				tac_pkg::MP_DOWN: s_d.chRef[ch] = matchEvt[ch] && !cntUp;
				tac_pkg::MP_BOTH: s_d.chRef[ch] = matchEvt[ch];
			endcase
			if (!shadowEn[ch] || updateEvt)
			begin
				s_d.cmpSh[ch] = memWords[ch*tac_pkg::DATA_W +: tac_pkg::DATA_W];
			end
			if (!s_q.auxCtrl[tac_pkg::CPWM_LSB + ch])
			begin
				s_d.addSh[ch] = '0;
			end
			else if (!shadowEn[ch] || updateEvt)
			begin
				s_d.addSh[ch] = memWords[(ch+tac_pkg::CH_NUM)*tac_pkg::DATA_W +: tac_pkg::DATA_W];
			end
		end

		if (!nrst)
		begin
			s_d = '0;
			s_d.auxCtrl = tac_pkg::RST_AUX_CTRL;
			s_d.wdgPeriod = tac_pkg::RST_WDG_PERIOD;
			s_d.dmaCfg = tac_pkg::RST_DMA_CFG;
			s_d.miscCfg = tac_pkg::RST_MISC_CFG;
		end
	end

	always_ff @(posedge clk)
	begin
		s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all straight from state

	assign busRdata = s_q.rdata;
	assign busAck = s_q.ack;
	assign compareRef = s_q.chRef;
	assign compositePwmEn = s_q.auxCtrl[tac_pkg::CPWM_LSB +: tac_pkg::CH_NUM];
	assign compareValue = s_q.cmpSh;
	assign addCompareValue = s_q.addSh;
	assign jumpDetected = s_q.jump;
	assign disconnectFlag = s_q.flag;
	assign disconnectIrq = s_q.irq;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_ctl2Wr;
		s_q.st == tac_pkg::ST_IDLE && busValid && busWrite && busAddr == tac_pkg::OFF_AUX_CTRL;
	endsequence

	sequence s_winReq;
		s_q.st == tac_pkg::ST_IDLE && busValid && busAddr == tac_pkg::OFF_DMA_WINDOW;
	endsequence

	a_cpwm_write_lands: assert property (s_ctl2Wr |-> ##2
		compositePwmEn == $past(busWdata[31:28], 2) && busAck)
		else $error("composite enables do not follow control write");
	a_wdg_idle_off: assert property (!s_q.auxCtrl[19] |=> s_q.cntA == 0 && s_q.cntB == 0)
		else $error("watchdog counts while detection disabled");
	a_jump_detect: assert property ((quadA != s_q.prevA) && (quadB != s_q.prevB)
		|=> jumpDetected == $past(s_q.auxCtrl[18]))
		else $error("jump detection wrong");
	a_ref_normal: assert property (s_q.auxCtrl[9:8] == 2'b00 |=> compareRef[0] == $past(normalRef[0]))
		else $error("normal reference not followed");
	a_ref_up_only: assert property (s_q.auxCtrl[9:8] == 2'b01
		|=> compareRef[0] == $past(matchEvt[0] && cntUp))
		else $error("up only pulse wrong");
	a_ref_down_only: assert property (s_q.auxCtrl[11:10] == 2'b10
		|=> compareRef[1] == $past(matchEvt[1] && !cntUp))
		else $error("down only pulse wrong");
	a_ref_both_dirs: assert property (s_q.auxCtrl[15:14] == 2'b11 && matchEvt[3]
		##1 s_q.auxCtrl[15:14] == 2'b11 && !matchEvt[3] |-> compareRef[3] ##1 !compareRef[3])
		else $error("match pulse not one cycle");
	a_wdg_timeout_flag: assert property (s_q.auxCtrl[19] && quadA == s_q.prevA
		&& s_q.cntA == s_q.wdgPeriod |=> disconnectFlag && s_q.cntA == 0)
		else $error("timeout did not set flag");
	a_irq_gated: assert property (disconnectIrq |-> $past(disconnectIrqEn) && disconnectFlag)
		else $error("interrupt without enable");
	a_burst_wrap: assert property (s_winReq and s_q.burstIdx >= s_q.dmaCfg[13:8]
		|=> s_q.burstIdx == 0)
		else $error("transfer index did not wrap");
	a_burst_step: assert property (s_winReq and s_q.burstIdx < s_q.dmaCfg[13:8]
		|=> s_q.burstIdx == $past(s_q.burstIdx) + 6'h01)
		else $error("transfer index did not step");
	a_burst_start: assert property (s_winReq and s_q.burstIdx == 0
		|=> s_q.pAddr == {2'b00, $past(s_q.dmaCfg[5:0]), 2'b00})
		else $error("burst does not start at start index");
	a_skip_same: assert property (s_q.st == tac_pkg::ST_EXEC && s_q.pWrite && slotExec[3]
		&& !slotExec[2] |-> memWrEn == !(s_q.miscCfg[1] && memRdData == s_q.pWdata))
		else $error("identical write filter wrong");
	a_wdg_edge_restart: assert property (s_q.auxCtrl[19] && quadB != s_q.prevB |=> s_q.cntB == 0)
		else $error("watchdog not restarted by edge");
	a_add_cpwm_only: assert property (!s_q.auxCtrl[28] |=> addCompareValue[31:0] == 0)
		else $error("additional compare active outside composite mode");

endmodule

//--- sim/tac_bus_master.sv
// tac_bus_master: register port master in place of the cpu and dma side.
// assumes tac_pkg compiled first; requests launched at falling edges.
`timescale 1ns/100ps
module tac_bus_master (
	input wire logic clk,
	input wire logic busAck,
	output logic busValid,
	output logic busWrite,
	output logic [tac_pkg::ADDR_W-1:0] busAddr,
	output logic [tac_pkg::DATA_W-1:0] busWdata
);
	initial
	begin
		busValid = 1'b0;
		busWrite = 1'b0;
		busAddr = '0;
		busWdata = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// one-cycle strobe, whole words only; released lines show inverted
	// values so a stale address or data is never mistaken for a live one
	task automatic xfer(input logic wr, input logic [tac_pkg::ADDR_W-1:0] a,
		input logic [tac_pkg::DATA_W-1:0] d);
		int n;
		@(negedge clk);
		busValid = 1'b1;
		busWrite = wr;
		busAddr = a;
		busWdata = d;
		@(negedge clk);
		busValid = 1'b0;
		busAddr = ~a;
		busWdata = ~d;
		n = 0;
		while (busAck !== 1'b1 && n < 8)
		begin
			@(negedge clk);
			n++;
		end
	endtask
endmodule

//--- sim/tac_aux_ctrl_tb.sv
// tac_aux_ctrl_tb: self-checking bench of the timer auxiliary control slice.
// assumes tac_pkg, tac_cmp_store, tac_aux_ctrl and tac_bus_master compiled.
`timescale 1ns/100ps
module tac_aux_ctrl_tb;
	logic clk, nrst, busValid, busWrite, busAck, cntUp, updateEvt;
	logic quadA, quadB, disconnectIrqEn, disconnectFlagClr;
	logic jumpDetected, disconnectFlag, disconnectIrq;
	logic [tac_pkg::ADDR_W-1:0] busAddr;
	logic [31:0] busWdata, busRdata;
	logic [3:0] matchEvt, normalRef, shadowEn, compareRef, compositePwmEn;
	logic [127:0] compareValue, addCompareValue;
	logic [31:0] expQ[$];
	int error_cnt = 0;
	int check_count = 0;
	int cyc = 0;

	tac_aux_ctrl dut (
		.clk,
		.nrst,
		.busValid,
		.busWrite,
		.busAddr,
		.busWdata,
		.busRdata,
		.busAck,
		.cntUp,
		.matchEvt,
		.normalRef,
		.updateEvt,
		.shadowEn,
		.quadA,
		.quadB,
		.disconnectIrqEn,
		.disconnectFlagClr,
		.compareRef,
		.compositePwmEn,
		.compareValue,
		.addCompareValue,
		.jumpDetected,
		.disconnectFlag,
		.disconnectIrq
	);

	tac_bus_master bfm (
		.clk,
		.busAck,
		.busValid,
		.busWrite,
		.busAddr,
		.busWdata
	);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		if (expQ.size() != 0)
			error_cnt++;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk_port(input logic [127:0] got, input logic [127:0] exp);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
		chk_port({96'h0, got}, {96'h0, exp});
	endtask

	// writes answer with zero read data
	task automatic wr(input logic [tac_pkg::ADDR_W-1:0] a, input logic [31:0] d);
		expQ.push_back(32'h0);
		bfm.xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [tac_pkg::ADDR_W-1:0] a, input logic [31:0] e);
		expQ.push_back(e);
		bfm.xfer(1'b0, a, 32'h0);
	endtask

	task automatic jump_try(input logic ta, input logic tbv, input int exp);
		int n;
		n = 0;
		@(negedge clk);
		quadA = quadA ^ ta;
		quadB = quadB ^ tbv;
		repeat (4)
		begin
			@(negedge clk);
			n += int'(jumpDetected === 1'b1);
		end
		chk_port(128'(n), 128'(exp));
	endtask

	// oldest note answers each acknowledge
	always @(posedge clk)
	begin
		cyc++;
		if (busAck === 1'b1)
		begin
			if (expQ.size() == 0)
			begin
				error_cnt++;
				$display("CHECK FAILED at %0t: got %0h expected none", $time, busRdata);
			end
			else
				chk_rd(busRdata, expQ.pop_front());
		end
		if (cyc == 20000)
		begin
			error_cnt++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [31:0] cfg;
		logic [31:0] v[4];
		logic [3:0] e;
		logic [1:0] m;
		int i, c, k;
		nrst = 1'b0;
		cntUp = 1'b0;
		matchEvt = 4'h0;
		normalRef = 4'h0;
		updateEvt = 1'b0;
		shadowEn = 4'h0;
		quadA = 1'b0;
		quadB = 1'b0;
		disconnectIrqEn = 1'b0;
		disconnectFlagClr = 1'b0;
		void'($urandom(32'h2D02B0CF));
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		rd(tac_pkg::OFF_AUX_CTRL, 32'h0);
		rd(tac_pkg::OFF_WDG_PERIOD, 32'hFFFFFFFF);
		rd(tac_pkg::OFF_DMA_CFG, 32'h0);
		rd(tac_pkg::OFF_MISC_CFG, 32'h0);
		wr(10'h3F0, 32'hFFFFFFFF);
		rd(10'h3F0, 32'h0);
		// reserved bits kept at zero, every writable bit set
		wr(tac_pkg::OFF_AUX_CTRL, 32'hF00CFF00);
		chk_port(128'(compositePwmEn), 128'h0F);
		rd(tac_pkg::OFF_AUX_CTRL, 32'hF00CFF00);
		wr(tac_pkg::OFF_DMA_CFG, 32'h00003F3F);
		rd(tac_pkg::OFF_DMA_CFG, 32'h00003F3F);
		wr(tac_pkg::OFF_MISC_CFG, 32'h00000002);
		rd(tac_pkg::OFF_MISC_CFG, 32'h00000002);

		// every select code on every channel within four passes
		for (i = 0; i < 16; i++)
		begin
			cfg = 32'h0;
			for (c = 0; c < 4; c++)
				cfg[8+2*c +: 2] = 2'(i + c);
			cfg[31:28] = 4'($urandom());
			wr(tac_pkg::OFF_AUX_CTRL, cfg);
			chk_port(128'(compositePwmEn), 128'(cfg[31:28]));
			for (k = 0; k < 8; k++)
			begin
				cntUp = 1'($urandom());
				matchEvt = k[0] ? 4'($urandom()) : 4'h0;
				normalRef = 4'($urandom());
				for (c = 0; c < 4; c++)
				begin
					m = cfg[8+2*c +: 2];
					e[c] = (m == 2'h0) ? normalRef[c] : matchEvt[c] & ((m == 2'h3) ||
						(m == 2'h1 && cntUp) || (m == 2'h2 && !cntUp));
				end
				@(negedge clk);
				chk_port(128'(compareRef), 128'(e));
			end
		end

		for (i = 0; i < 4; i++)
			v[i] = $urandom();
		shadowEn = 4'h8;
		wr(tac_pkg::OFF_CH3_CV, v[3]);
		repeat (3) @(negedge clk);
		chk_port(128'(compareValue[127:96]), 128'h0);
		updateEvt = 1'b1;
		@(negedge clk);
		updateEvt = 1'b0;
		repeat (2) @(negedge clk);
		chk_port(128'(compareValue[127:96]), 128'(v[3]));
		shadowEn = 4'h0;
		wr(tac_pkg::OFF_AUX_CTRL, 32'h10000000);
		wr(tac_pkg::OFF_CH0_ADD, v[0]);
		repeat (3) @(negedge clk);
		chk_port(128'(addCompareValue[31:0]), 128'(v[0]));
		wr(tac_pkg::OFF_AUX_CTRL, 32'h0);
		repeat (3) @(negedge clk);
		chk_port(128'(addCompareValue[31:0]), 128'h0);

		// burst of four through the window onto the compare values
		wr(tac_pkg::OFF_DMA_CFG, 32'h0000030D);
		for (i = 0; i < 4; i++)
			wr(tac_pkg::OFF_DMA_WINDOW, v[i]);
		for (i = 0; i < 4; i++)
			rd(tac_pkg::OFF_CH0_CV + 10'(4 * i), v[i]);
		for (i = 0; i < 4; i++)
			rd(tac_pkg::OFF_DMA_WINDOW, v[i]);
		wr(tac_pkg::OFF_DMA_CFG, 32'h0000001D);
		wr(tac_pkg::OFF_DMA_WINDOW, 32'h20000000);
		chk_port(128'(compositePwmEn), 128'h02);
		rd(tac_pkg::OFF_DMA_WINDOW, 32'h20000000);

		wr(tac_pkg::OFF_WDG_PERIOD, 32'h0000000A);
		wr(tac_pkg::OFF_AUX_CTRL, 32'h0);
		repeat (40) @(negedge clk);
		chk_port(128'(disconnectFlag), 128'h0);
		wr(tac_pkg::OFF_AUX_CTRL, 32'h00080000);
		for (k = 0; k < 60; k++)
		begin
			@(negedge clk);
			quadA = quadA ^ (k % 5 == 0);
			quadB = quadB ^ (k % 5 == 2);
		end
		chk_port(128'(disconnectFlag), 128'h0);
		disconnectIrqEn = 1'b1;
		k = 0;
		while (disconnectFlag !== 1'b1 && k < 30)
		begin
			@(negedge clk);
			k++;
		end
		chk_port(128'(disconnectFlag), 128'h1);
		@(negedge clk);
		chk_port(128'(disconnectIrq), 128'h1);
		disconnectIrqEn = 1'b0;
		@(negedge clk);
		chk_port(128'(disconnectIrq), 128'h0);
		// stop detection first so no fresh timeout re-sets the flag
		wr(tac_pkg::OFF_AUX_CTRL, 32'h0);
		disconnectFlagClr = 1'b1;
		@(negedge clk);
		disconnectFlagClr = 1'b0;
		chk_port(128'(disconnectFlag), 128'h0);
		for (k = 0; k < 24; k++)
		begin
			@(negedge clk);
			chk_port(128'(disconnectIrq), 128'h0);
		end

		wr(tac_pkg::OFF_AUX_CTRL, 32'h00040000);
		jump_try(1'b1, 1'b1, 1);
		jump_try(1'b1, 1'b0, 0);
		wr(tac_pkg::OFF_AUX_CTRL, 32'h0);
		jump_try(1'b1, 1'b1, 0);
		repeat (4) @(negedge clk);
		give_verdict();
	end
endmodule
